// ### inc/seq_ctrl_pkg.sv
package seq_ctrl_pkg;

  // Instruction opcodes
  localparam logic [7:0] OP_DATA_MAX = 8'h7f;
  localparam logic [7:0] OP_IO_UPDATE = 8'h80;
  localparam logic [7:0] OP_CAL_BOTH = 8'h90;
  localparam logic [7:0] OP_CAL_A = 8'h91;
  localparam logic [7:0] OP_CAL_B = 8'h92;
  localparam logic [7:0] OP_FREE_BOTH = 8'h98;
  localparam logic [7:0] OP_FREE_A = 8'h99;
  localparam logic [7:0] OP_FREE_B = 8'h9a;
  localparam logic [7:0] OP_SYNC_ALL = 8'ha0;
  localparam logic [7:0] OP_SYNC_A = 8'ha1;
  localparam logic [7:0] OP_SYNC_B = 8'ha2;
  localparam logic [3:0] OP_COND_NIBBLE = 4'hb;
  localparam logic [7:0] OP_PAUSE = 8'hfe;
  localparam logic [7:0] OP_END = 8'hff;

  // Widths and depths
  localparam int SP_AW = 6;
  localparam int SP_DEPTH = 64;
  localparam int NV_AW = 11;
  localparam int MAP_AW = 16;
  localparam int TAGS = 16;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COND = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [1:0] REG_SP_PAGE = 2'h1;

  // Field positions
  localparam int CTRL_WR_EN_BIT = 0;
  localparam int CTRL_SAVE_BIT = 1;
  localparam int CTRL_LOAD_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;
  localparam int STAT_DONE_BIT = 2;

  // Reset values
  localparam logic [3:0] COND_RESET = 4'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_OP_REQ, ST_OP_GAP, ST_OP_USE, ST_ADR_REQ, ST_ADR_GAP, ST_ADR_USE,
    ST_DAT_REQ, ST_DAT_GAP, ST_DAT_USE, ST_SUM_REQ, ST_SUM_GAP, ST_SUM_USE
  } seq_state_t;

endpackage

// ### src/byte_ram.sv
`timescale 1ns/1ps
module byte_ram (
  input wire logic clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [seq_ctrl_pkg::SP_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic [seq_ctrl_pkg::SP_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  import seq_ctrl_pkg::*;

  typedef struct packed {
    logic [SP_DEPTH-1:0][7:0] mem;
    logic [7:0] rd_data;
  } ram_t;

  ram_t q, d;

  // Write port and registered read port
  always_comb begin
    d = q;
    if (wr_en) begin
      d.mem[wr_addr] = wr_data;
    end
    if (rd_en) begin
      d.rd_data = q.mem[rd_addr];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
endmodule

// ### src/cond_tag_board.sv
`timescale 1ns/1ps
module cond_tag_board (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic tag_stb,
  input wire logic [3:0] tag_code,
  input wire logic [3:0] cond,
  output logic exec
);
  import seq_ctrl_pkg::*;

  typedef struct packed {
    logic [TAGS-1:0] board;
  } tag_t;

  tag_t q, d;

  // Null code wipes the board, other codes add a tag
  always_comb begin
    d = q;
    if (clear) begin
      d.board = '0;
    end else if (tag_stb) begin
      if (tag_code == 4'h0) begin
        d.board = '0;
      end else begin
        d.board[tag_code] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Run all with null condition or empty board, else only when tagged
  assign exec = (cond == 4'h0) || (q.board == '0) || q.board[cond];
endmodule

// ### src/eeprom_sequence_controller.sv
`timescale 1ns/1ps
module eeprom_sequence_controller (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rd_data,
  output logic [seq_ctrl_pkg::MAP_AW-1:0] map_addr,
  output logic [7:0] map_wdata,
  output logic map_wr,
  output logic map_rd,
  input wire logic [7:0] map_rdata,
  output logic [seq_ctrl_pkg::NV_AW-1:0] nv_addr,
  output logic [7:0] nv_wdata,
  output logic nv_wr,
  output logic nv_rd,
  input wire logic [7:0] nv_rdata,
  input wire logic [1:0] powerup_pin_state,
  input wire logic sysclk_stable,
  input wire logic analog_loop_a_locked,
  input wire logic analog_loop_b_locked,
  input wire logic sync_override,
  output logic io_update,
  output logic cal_analog_loop_a,
  output logic cal_analog_loop_b,
  output logic freerun_digital_loop_a,
  output logic freerun_digital_loop_b,
  output logic sync_group_a,
  output logic sync_group_b
);
  import seq_ctrl_pkg::*;

  typedef struct packed {
    seq_state_t st;
    logic up;
    logic [SP_AW-1:0] sp_ptr;
    logic [NV_AW-1:0] nv_ptr;
    logic [MAP_AW-1:0] map_ptr;
    logic [6:0] cnt;
    logic adr_idx;
    logic run;
    logic [7:0] csum;
    logic wr_en;
    logic fault;
    logic done;
    logic [3:0] cond;
    logic [1:0] pins;
    logic pins_taken;
    logic [1:0] cal_pend;
    logic [1:0] sync_pend;
    logic sp_rd;
    logic [7:0] rd_data;
    logic [MAP_AW-1:0] map_addr;
    logic [7:0] map_wdata;
    logic map_wr;
    logic map_rd;
    logic [NV_AW-1:0] nv_addr;
    logic [7:0] nv_wdata;
    logic nv_wr;
    logic nv_rd;
    logic io_update;
    logic [1:0] cal;
    logic [1:0] freerun;
    logic [1:0] sync;
  } ctl_t;

  ctl_t q, d;
  logic [7:0] sp_rdata;
  logic sp_wr;
  logic tag_clear;
  logic tag_stb;
  logic exec;
  logic [3:0] active_cond;
  logic [7:0] src_byte;
  logic [1:0] cal_req;
  logic [1:0] sync_req;
  logic [1:0] cal_fire;
  logic [1:0] sync_fire;

  // True when a bus address falls on a given register
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction

  // Scratchpad: software writes, controller reads
  assign sp_wr = wr && (addr[7:6] == REG_SP_PAGE);

  byte_ram sp_ram (
    .clk(clk),
    .reset(reset),
    .wr_en(sp_wr),
    .wr_addr(addr[SP_AW-1:0]),
    .wr_data(wr_data),
    .rd_en(q.sp_rd),
    .rd_addr(q.sp_ptr),
    .rd_data(sp_rdata)
  );

  // Register field wins when nonzero, else the captured pins
  assign active_cond = (q.cond != 4'h0) ? q.cond : {2'b00, q.pins};

  cond_tag_board tags (
    .clk(clk),
    .reset(reset),
    .clear(tag_clear),
    .tag_stb(tag_stb),
    .tag_code(src_byte[3:0]),
    .cond(active_cond),
    .exec(exec)
  );

  // Sequence bytes come from the scratchpad on upload, the store on download
  assign src_byte = q.up ? sp_rdata : nv_rdata;

  // Lock and clock-stable gating of the held requests
  assign cal_fire = q.cal_pend & {2{sysclk_stable}};
  assign sync_fire = q.sync_pend & ({analog_loop_b_locked, analog_loop_a_locked} | {2{sync_override}});

  always_comb begin
    d = q;
    d.sp_rd = 1'b0;
    d.map_wr = 1'b0;
    d.map_rd = 1'b0;
    d.nv_wr = 1'b0;
    d.nv_rd = 1'b0;
    d.io_update = 1'b0;
    d.rd_data = BYTE_RESET;
    tag_clear = 1'b0;
    tag_stb = 1'b0;
    cal_req = 2'b00;
    sync_req = 2'b00;

    // Capture the pin state once after reset release
    if (!q.pins_taken) begin
      d.pins = powerup_pin_state;
      d.pins_taken = 1'b1;
    end

    // Register writes
    if (wr && reg_hit(addr, REG_CTRL)) begin
      d.wr_en = wr_data[CTRL_WR_EN_BIT];
    end
    if (wr && reg_hit(addr, REG_COND)) begin
      d.cond = wr_data[3:0];
    end

    // Register reads, data valid the following cycle only
    if (rd && reg_hit(addr, REG_CTRL)) begin
      d.rd_data[CTRL_WR_EN_BIT] = q.wr_en;
    end else if (rd && reg_hit(addr, REG_COND)) begin
      d.rd_data[3:0] = q.cond;
    end else if (rd && reg_hit(addr, REG_STATUS)) begin
      d.rd_data[STAT_BUSY_BIT] = (q.st != ST_IDLE);
      d.rd_data[STAT_FAULT_BIT] = q.fault;
      d.rd_data[STAT_DONE_BIT] = q.done;
    end

    unique case (q.st)
      ST_IDLE: begin
        if (wr && reg_hit(addr, REG_CTRL) && wr_data[CTRL_LOAD_BIT]) begin
          d.up = 1'b0;
          d.fault = 1'b0;
          d.done = 1'b0;
          tag_clear = 1'b1;
          d.st = ST_OP_REQ;
        end else if (wr && reg_hit(addr, REG_CTRL) && wr_data[CTRL_SAVE_BIT] && wr_data[CTRL_WR_EN_BIT]) begin
          d.up = 1'b1;
          d.st = ST_OP_REQ;
        end
      end
      ST_OP_REQ: begin
        d.sp_rd = q.up;
        d.nv_rd = !q.up;
        d.nv_addr = q.nv_ptr;
        d.st = ST_OP_GAP;
      end
      ST_OP_GAP: begin
        d.st = ST_OP_USE;
      end
      ST_OP_USE: begin
        d.st = ST_OP_REQ;
        if (q.up) begin
          d.sp_ptr = SP_AW'(q.sp_ptr + 6'd1);
        end else begin
          d.nv_ptr = NV_AW'(q.nv_ptr + 11'd1);
        end
        if (src_byte <= OP_DATA_MAX) begin
          d.cnt = src_byte[6:0];
          d.csum = BYTE_RESET;
          d.adr_idx = 1'b0;
          d.run = q.up || exec;
          d.st = ST_ADR_REQ;
        end else if (src_byte == OP_PAUSE && q.up) begin
          d.sp_ptr = '0;
          d.st = ST_IDLE;
        end else if (src_byte == OP_END) begin
          d.nv_ptr = '0;
          d.st = ST_IDLE;
          if (q.up) begin
            d.sp_ptr = '0;
          end else begin
            d.done = !q.fault;
          end
        end else if (!q.up && src_byte[7:4] == OP_COND_NIBBLE) begin
          tag_stb = 1'b1;
        end else if (!q.up && exec) begin
          unique case (src_byte)
            OP_IO_UPDATE: d.io_update = 1'b1;
            OP_CAL_BOTH: cal_req = 2'b11;
            OP_CAL_A: cal_req = 2'b01;
            OP_CAL_B: cal_req = 2'b10;
            OP_FREE_BOTH, OP_FREE_A, OP_FREE_B: d.freerun = 2'b11;
            OP_SYNC_ALL: sync_req = 2'b11;
            OP_SYNC_A: sync_req = 2'b01;
            OP_SYNC_B: sync_req = 2'b10;
            default: d.io_update = 1'b0;
          endcase
        end
        // Upload copies every byte except a pause into the store
        if (q.up && src_byte != OP_PAUSE) begin
          d.nv_wr = 1'b1;
          d.nv_addr = q.nv_ptr;
          d.nv_wdata = src_byte;
          if (src_byte != OP_END) begin
            d.nv_ptr = NV_AW'(q.nv_ptr + 11'd1);
          end
        end
      end
      ST_ADR_REQ: begin
        d.sp_rd = q.up;
        d.nv_rd = !q.up;
        d.nv_addr = q.nv_ptr;
        d.st = ST_ADR_GAP;
      end
      ST_ADR_GAP: begin
        d.st = ST_ADR_USE;
      end
      ST_ADR_USE: begin
        // First address byte is the high half
        if (!q.adr_idx) begin
          d.map_ptr[15:8] = src_byte;
          d.adr_idx = 1'b1;
          d.st = ST_ADR_REQ;
        end else begin
          d.map_ptr[7:0] = src_byte;
          d.st = ST_DAT_REQ;
        end
        d.nv_ptr = NV_AW'(q.nv_ptr + 11'd1);
        if (q.up) begin
          d.sp_ptr = SP_AW'(q.sp_ptr + 6'd1);
          d.nv_wr = 1'b1;
          d.nv_addr = q.nv_ptr;
          d.nv_wdata = src_byte;
        end
      end
      ST_DAT_REQ: begin
        d.map_rd = q.up;
        d.map_addr = q.map_ptr;
        d.nv_rd = !q.up;
        d.nv_addr = q.nv_ptr;
        d.st = ST_DAT_GAP;
      end
      ST_DAT_GAP: begin
        d.st = ST_DAT_USE;
      end
      ST_DAT_USE: begin
        if (q.up) begin
          d.csum = 8'(q.csum + map_rdata);
          d.nv_wr = 1'b1;
          d.nv_addr = q.nv_ptr;
          d.nv_wdata = map_rdata;
        end else begin
          d.csum = 8'(q.csum + nv_rdata);
          d.map_wr = q.run;
          d.map_addr = q.map_ptr;
          d.map_wdata = nv_rdata;
        end
        d.nv_ptr = NV_AW'(q.nv_ptr + 11'd1);
        d.map_ptr = MAP_AW'(q.map_ptr + 16'h0001);
        if (q.cnt == 7'h00) begin
          d.st = ST_SUM_REQ;
        end else begin
          d.cnt = 7'(q.cnt - 7'h01);
          d.st = ST_DAT_REQ;
        end
      end
      ST_SUM_REQ: begin
        d.nv_addr = q.nv_ptr;
        if (q.up) begin
          d.nv_wr = 1'b1;
          d.nv_wdata = q.csum;
          d.nv_ptr = NV_AW'(q.nv_ptr + 11'd1);
          d.st = ST_OP_REQ;
        end else begin
          d.nv_rd = 1'b1;
          d.st = ST_SUM_GAP;
        end
      end
      ST_SUM_GAP: begin
        d.st = ST_SUM_USE;
      end
      ST_SUM_USE: begin
        if (nv_rdata != q.csum) begin
          d.fault = 1'b1;
        end
        d.nv_ptr = NV_AW'(q.nv_ptr + 11'd1);
        d.st = ST_OP_REQ;
      end
      default: d.st = ST_IDLE;
    endcase

    // One-cycle side effects; a new request beats the clear of a pending one
    if (q.st != ST_OP_USE) begin
      d.freerun = 2'b00;
    end
    d.cal = cal_fire;
    d.sync = sync_fire;
    d.cal_pend = (q.cal_pend & ~cal_fire) | cal_req;
    d.sync_pend = (q.sync_pend & ~sync_fire) | sync_req;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cond <= COND_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign rd_data = q.rd_data;
  assign map_addr = q.map_addr;
  assign map_wdata = q.map_wdata;
  assign map_wr = q.map_wr;
  assign map_rd = q.map_rd;
  assign nv_addr = q.nv_addr;
  assign nv_wdata = q.nv_wdata;
  assign nv_wr = q.nv_wr;
  assign nv_rd = q.nv_rd;
  assign io_update = q.io_update;
  assign cal_analog_loop_a = q.cal[0];
  assign cal_analog_loop_b = q.cal[1];
  assign freerun_digital_loop_a = q.freerun[0];
  assign freerun_digital_loop_b = q.freerun[1];
  assign sync_group_a = q.sync[0];
  assign sync_group_b = q.sync[1];
endmodule

// ### verification/eeprom_sequence_controller_monitor.sv
`timescale 1ns/1ps
module eeprom_sequence_controller_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [7:0] rd_data,
  input wire logic map_rd,
  input wire logic [7:0] map_rdata,
  input wire logic nv_rd,
  input wire logic nv_wr,
  input wire logic [7:0] nv_wdata,
  input wire logic sysclk_stable,
  input wire logic analog_loop_a_locked,
  input wire logic analog_loop_b_locked,
  input wire logic sync_override,
  input wire logic io_update,
  input wire logic cal_analog_loop_a,
  input wire logic cal_analog_loop_b,
  input wire logic freerun_digital_loop_a,
  input wire logic freerun_digital_loop_b,
  input wire logic sync_group_a,
  input wire logic sync_group_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Read data shows only after a read of a mapped register
  a_rd_idle_zero: assert property (!rd |=> rd_data == 8'h00)
    else $error("read data not zero without a read");
  a_rd_unmapped_zero: assert property (rd && addr > 8'h02 |=> rd_data == 8'h00)
    else $error("unmapped or write-only read not zero");
  // Store reads keep their spacing
  a_nv_rd_gap: assert property (nv_rd |=> !nv_rd [*2])
    else $error("store reads too close");
  // Uploaded byte is the one just read from the map
  a_upload_byte_copy: assert property (nv_wr && $past(map_rd, 2) |-> nv_wdata == $past(map_rdata))
    else $error("stored byte differs from map byte");
  // Side pulses follow a decode or their gate
  a_io_after_fetch: assert property (io_update |-> $past(nv_rd, 2))
    else $error("update strobe without fetched opcode");
  a_cal_a_gated: assert property (cal_analog_loop_a |-> $past(sysclk_stable))
    else $error("calibration a without stable clock");
  a_cal_b_gated: assert property (cal_analog_loop_b |-> $past(sysclk_stable))
    else $error("calibration b without stable clock");
  a_freerun_both: assert property (freerun_digital_loop_a == freerun_digital_loop_b)
    else $error("free-run pulses not paired");
  a_sync_a_gated: assert property (sync_group_a |-> $past(analog_loop_a_locked | sync_override))
    else $error("sync a without lock");
  a_sync_b_gated: assert property (sync_group_b |-> $past(analog_loop_b_locked | sync_override))
    else $error("sync b without lock");
endmodule

bind eeprom_sequence_controller eeprom_sequence_controller_monitor mon_u (
  .clk(clk), .reset(reset), .addr(addr), .rd(rd), .rd_data(rd_data),
  .map_rd(map_rd), .map_rdata(map_rdata), .nv_rd(nv_rd), .nv_wr(nv_wr), .nv_wdata(nv_wdata),
  .sysclk_stable(sysclk_stable), .analog_loop_a_locked(analog_loop_a_locked),
  .analog_loop_b_locked(analog_loop_b_locked), .sync_override(sync_override),
  .io_update(io_update), .cal_analog_loop_a(cal_analog_loop_a), .cal_analog_loop_b(cal_analog_loop_b),
  .freerun_digital_loop_a(freerun_digital_loop_a), .freerun_digital_loop_b(freerun_digital_loop_b),
  .sync_group_a(sync_group_a), .sync_group_b(sync_group_b)
);

// ### verification/nv_map_model.sv
`timescale 1ns/1ps
module nv_map_model (
  input wire logic clk,
  input wire logic [seq_ctrl_pkg::MAP_AW-1:0] map_addr,
  input wire logic [7:0] map_wdata,
  input wire logic map_wr,
  input wire logic map_rd,
  output logic [7:0] map_rdata,
  input wire logic [seq_ctrl_pkg::NV_AW-1:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_wr,
  input wire logic nv_rd,
  output logic [7:0] nv_rdata
);
  import seq_ctrl_pkg::*;
  logic [7:0] nv_mem [0:2**NV_AW-1];
  logic [7:0] map_mem [0:2**MAP_AW-1];

  initial begin
    map_rdata = 8'h00;
    nv_rdata = 8'h00;
  end

  // Data valid one cycle after a read, scrambled at every other time
  always @(posedge clk) begin
    if (nv_wr) nv_mem[nv_addr] <= nv_wdata;
    if (map_wr) map_mem[map_addr] <= map_wdata;
    nv_rdata <= nv_rd ? nv_mem[nv_addr] : ~nv_rdata;
    map_rdata <= map_rd ? map_mem[map_addr] : ~map_rdata;
  end
endmodule

// ### verification/eeprom_sequence_controller_tb.sv
`timescale 1ns/1ps
module eeprom_sequence_controller_tb;
  import seq_ctrl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [1:0] powerup_pin_state = 2'b10;
  logic sysclk_stable = 1'b1;
  logic analog_loop_a_locked = 1'b1;
  logic analog_loop_b_locked = 1'b1;
  logic sync_override = 1'b0;
  logic [7:0] rd_data, map_wdata, map_rdata, nv_wdata, nv_rdata;
  logic [MAP_AW-1:0] map_addr;
  logic [NV_AW-1:0] nv_addr;
  logic map_wr, map_rd, nv_wr, nv_rd;
  logic [6:0] ev;
  int cnt [7];
  int num_errors = 0;
  int comparisons = 0;

  eeprom_sequence_controller dut_u (
    .clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data),
    .map_addr(map_addr), .map_wdata(map_wdata), .map_wr(map_wr), .map_rd(map_rd), .map_rdata(map_rdata),
    .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_wr(nv_wr), .nv_rd(nv_rd), .nv_rdata(nv_rdata),
    .powerup_pin_state(powerup_pin_state), .sysclk_stable(sysclk_stable),
    .analog_loop_a_locked(analog_loop_a_locked), .analog_loop_b_locked(analog_loop_b_locked),
    .sync_override(sync_override), .io_update(ev[6]), .cal_analog_loop_a(ev[5]), .cal_analog_loop_b(ev[4]),
    .freerun_digital_loop_a(ev[3]), .freerun_digital_loop_b(ev[2]), .sync_group_a(ev[1]), .sync_group_b(ev[0])
  );

  nv_map_model mdl_u (
    .clk(clk), .map_addr(map_addr), .map_wdata(map_wdata), .map_wr(map_wr), .map_rd(map_rd),
    .map_rdata(map_rdata), .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_wr(nv_wr), .nv_rd(nv_rd),
    .nv_rdata(nv_rdata)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // Count every side pulse
  always @(posedge clk) begin
    foreach (ev[i]) if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 1;
  end

  task automatic complete_run();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [27:0] got, input logic [27:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_val({20'h0_0000, got}, {20'h0_0000, exp});
  endtask

  // One nibble per pulse count, update strobe in the top nibble
  task automatic check_evts(input logic [27:0] exp);
    logic [27:0] got;
    foreach (cnt[i]) got[4*i+:4] = cnt[i][3:0];
    check_val(got, exp);
  endtask

  task automatic clear_counts();
    @(negedge clk);
    cnt = '{default: 0};
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic wait_idle(output logic [7:0] s);
    s = 8'h01;
    for (int i = 0; i < 3000 && s[STAT_BUSY_BIT] !== 1'b0; i++) bus_rd(REG_STATUS, s);
    // A sequence that never finishes counts as a mismatch
    if (s[STAT_BUSY_BIT] !== 1'b0) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, s, 8'h00);
    end
  endtask

  task automatic load_sp(input logic [7:0] q [$]);
    foreach (q[i]) bus_wr(8'h40 + 8'(i), q[i]);
  endtask

  task automatic nv_fill(input logic [7:0] q [$]);
    foreach (q[i]) mdl_u.nv_mem[i] = q[i];
  endtask

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    logic [7:0] s;
    logic [7:0] exp_nv [$];
    clear_counts();
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    mdl_u.map_mem[16'h1234] = 8'h5a;
    mdl_u.map_mem[16'h1235] = 8'hc3;
    // Save without write enable is refused
    bus_wr(REG_CTRL, 8'h02);
    bus_rd(REG_STATUS, s);
    check_byte(s, 8'h00);
    // Upload a block, update, tag, unknown byte, then pause
    load_sp('{8'h01, 8'h12, 8'h34, 8'h80, 8'hb1, 8'hc5, 8'hfe});
    bus_wr(REG_CTRL, 8'h03);
    wait_idle(s);
    bus_rd(REG_CTRL, s);
    check_byte(s, 8'h01);
    bus_rd(8'h40, s);
    check_byte(s, 8'h00);
    bus_rd(8'h20, s);
    check_byte(s, 8'h00);
    // Second upload lands right behind the first
    load_sp('{8'ha0, 8'hff});
    bus_wr(REG_CTRL, 8'h03);
    wait_idle(s);
    exp_nv = '{8'h01, 8'h12, 8'h34, 8'h5a, 8'hc3, 8'h1d, 8'h80, 8'hb1, 8'hc5, 8'ha0, 8'hff};
    foreach (exp_nv[i]) check_byte(mdl_u.nv_mem[i], exp_nv[i]);
    check_evts(28'h000_0000);
    // Download with pin condition 2: block and update run, sync skipped
    mdl_u.map_mem[16'h1234] = 8'h00;
    mdl_u.map_mem[16'h1235] = 8'h00;
    bus_wr(REG_CTRL, 8'h05);
    wait_idle(s);
    check_byte(s, 8'h04);
    check_byte(mdl_u.map_mem[16'h1234], 8'h5a);
    check_byte(mdl_u.map_mem[16'h1235], 8'hc3);
    check_evts(28'h100_0000);
    // Corrupted check byte gives fault
    mdl_u.nv_mem[5] = 8'h1e;
    bus_wr(REG_CTRL, 8'h04);
    wait_idle(s);
    check_byte(s, 8'h02);
    // Conditional run with clock-stable and loop b lock gates closed
    nv_fill('{8'hb1, 8'h80, 8'hb0, 8'h91, 8'h92, 8'h90, 8'h98, 8'h99, 8'h9a, 8'ha0, 8'ha1, 8'ha2,
              8'hfe, 8'hc5, 8'hff});
    @(posedge clk);
    sysclk_stable <= 1'b0;
    analog_loop_b_locked <= 1'b0;
    bus_wr(REG_COND, 8'h02);
    bus_rd(REG_COND, s);
    check_byte(s, 8'h02);
    clear_counts();
    bus_wr(REG_CTRL, 8'h04);
    wait_idle(s);
    check_byte(s, 8'h04);
    check_evts(28'h000_3320);
    // Opening the gates releases the held pulses once
    @(posedge clk);
    sysclk_stable <= 1'b1;
    sync_override <= 1'b1;
    repeat (4) @(posedge clk);
    check_evts(28'h011_3321);
    // Unlocked loop a holds its own sync until lock
    sync_override <= 1'b0;
    analog_loop_a_locked <= 1'b0;
    nv_fill('{8'ha1, 8'hff});
    clear_counts();
    bus_wr(REG_CTRL, 8'h04);
    wait_idle(s);
    check_byte(s, 8'h04);
    check_evts(28'h000_0000);
    @(posedge clk);
    analog_loop_a_locked <= 1'b1;
    repeat (4) @(posedge clk);
    check_evts(28'h000_0010);
    complete_run();
  end
endmodule
